// file: rtl/otp_array.sv
// byte array storage, erased to zero, bits only ever added
`timescale 1ns/10ps
module otp_array #(
	parameter int AW = 13
) (
	// clock
	input wire logic mclk,
	// access port
	otp_mem_if.store mem
);
	logic [7:0] cells [0:(1<<AW)-1];
	logic [7:0] rdata_q;

	initial begin
		for (int i = 0; i < (1<<AW); i++) begin
			cells[i] = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (mem.wr_en) begin
			cells[mem.addr] <= cells[mem.addr] | mem.wdata;
		end
		if (mem.rd_en) begin
			rdata_q <= cells[mem.addr];
		end
	end

	assign mem.rdata = rdata_q;
endmodule : otp_array

// file: rtl/otp_consts.svh
// constants for the one-time-programmable array control block
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH
`define OTP_CLK_MHZ        10
`define OTP_CTRL_ADDR      16'h0007
`define OTP_OPTION_ADDR    16'h1EFE
`define OTP_SMALL_LO       13'h0100
`define OTP_SMALL_HI       13'h01FF
`define OTP_MAIN_LO        13'h0800
`define OTP_MAIN_HI        13'h1DFF
`define OTP_CTRL_FACTORY   7
`define OTP_CTRL_PROTECT   6
`define OTP_CTRL_LATCH     5
`define OTP_CTRL_PULSE     4
`define OTP_CTRL_EXTCLK    3
`define OTP_OPT_FACTORY    7
`define OTP_OPT_PROTECT    6
`define OTP_OPT_ZERO       5
`define OTP_OPT_HOLD       4
`define OTP_OPT_WD_RESET   3
`define OTP_OPT_WD_WAIT    2
`define OTP_OPT_PB_PD      1
`define OTP_OPT_PC_PD      0
`define OTP_OPT_RD_MASK    8'h5F
`define OTP_HOLD_SHORT     16
`define OTP_HOLD_LONG      4064
`define OTP_PIN_HOLD       2
`define OTP_PROG_FAST_US   5000
`define OTP_PROG_SLOW_US   20000
`define OTP_FLASH_HZ       3
`endif

// file: rtl/otp_mem_if.sv
// port between the control logic and the array storage
`timescale 1ns/10ps
interface otp_mem_if #(parameter int AW = 13);
	logic          rd_en;
	logic          wr_en;
	logic [AW-1:0] addr;
	logic [7:0]    wdata;
	logic [7:0]    rdata;
	modport ctrl (output rd_en, output wr_en, output addr, output wdata, input rdata);
	modport store (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : otp_mem_if

// file: rtl/otp_pkg.sv
// types shared by the array control block
package otp_pkg;
	typedef enum logic [2:0] {
		mode_single_chip,
		mode_erased_check,
		mode_parallel_load,
		mode_serial_load,
		mode_ram_parallel
	} boot_mode_t;
	typedef enum logic [2:0] {
		init_sync,
		init_opt_rd,
		init_opt_cap,
		init_hold,
		init_run
	} init_state_t;
	typedef enum logic [3:0] {
		boot_idle,
		boot_scan_rd,
		boot_scan_chk,
		boot_req,
		boot_wait_ack,
		boot_wait_rel,
		boot_prog,
		boot_cmp_rd,
		boot_cmp,
		boot_pass,
		boot_fail
	} boot_state_t;
	typedef enum logic [1:0] {
		eng_idle,
		eng_time,
		eng_write
	} eng_state_t;
endpackage : otp_pkg

// file: rtl/otp_program_control.sv
// programming control, option byte and bootstrap loader of the otp array
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "otp_consts.svh"
module otp_program_control #(
	parameter int AW         = 13,
	parameter int MAIN_HI    = `OTP_MAIN_HI,
	parameter int PROG_FAST  = `OTP_PROG_FAST_US * `OTP_CLK_MHZ,
	parameter int PROG_SLOW  = `OTP_PROG_SLOW_US * `OTP_CLK_MHZ,
	parameter int FLASH_HALF = (`OTP_CLK_MHZ * 1000000) / (2 * `OTP_FLASH_HZ)
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// register port
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// core status
	input  wire logic        stop_entry,
	input  wire logic [7:0]  port_b_dir,
	input  wire logic [7:0]  port_c_dir,
	// pins
	input  wire logic        programming_supply,
	input  wire logic        irq_boot_level,
	input  wire logic        capture_input_one,
	input  wire logic        port_d_line_two,
	input  wire logic        port_d_line_three,
	input  wire logic        port_d_line_four,
	input  wire logic [7:0]  port_a_in,
	input  wire logic        handshake_line_b,
	output logic             handshake_line_a,
	output logic [AW-1:0]    ext_addr,
	output logic             compare_output_one,
	output logic             led_green,
	output logic             led_red,
	// option, control register and boot mode outputs
	output logic             reset_hold_n,
	output logic             watchdog_after_reset_en,
	output logic             watchdog_in_wait_en,
	output logic [7:0]       port_b_pulldown_en,
	output logic [7:0]       port_c_pulldown_en,
	output logic             external_clock_option,
	output otp_pkg::boot_mode_t boot_mode
);
	localparam int PIN_W = 15;
	localparam logic [1:0] PIN_HOLD = 2'(`OTP_PIN_HOLD);
	// a lower main top shortens scans and loads and narrows the bus array window, the map start stays fixed
	localparam logic [AW-1:0] MAIN_TOP = AW'(MAIN_HI);

	function automatic logic is_main(input logic [AW-1:0] a);
		return (a >= `OTP_MAIN_LO) && (a <= MAIN_TOP);
	endfunction : is_main

	function automatic logic is_array(input logic [AW-1:0] a);
		return is_main(a) || ((a >= `OTP_SMALL_LO) && (a <= `OTP_SMALL_HI));
	endfunction : is_array

	// non-array segments are skipped on the way up
	function automatic logic [AW-1:0] next_array_addr(input logic [AW-1:0] a);
		return (a == `OTP_SMALL_HI) ? AW'(`OTP_MAIN_LO) : a + AW'(1);
	endfunction : next_array_addr

	otp_mem_if #(.AW(AW)) mem ();
	otp_array #(.AW(AW)) u_array (.mclk(mclk), .mem(mem.store));

	// pin synchronisers
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_s;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta <= '0;
			pin_s    <= '0;
		end else begin
			pin_meta <= {programming_supply, irq_boot_level, capture_input_one, port_d_line_two,
				port_d_line_three, port_d_line_four, handshake_line_b, port_a_in};
			pin_s    <= pin_meta;
		end
	end
	wire       supply_s = pin_s[14];
	wire       ack_s    = pin_s[8];
	wire [7:0] data_s   = pin_s[7:0];

	// state
	otp_pkg::init_state_t init_st;
	otp_pkg::boot_state_t boot_st;
	otp_pkg::eng_state_t  eng_st;
	logic [1:0]    pin_cnt;
	logic [11:0]   hold_cnt;
	logic [7:0]    option;
	logic          latch;
	logic          pulse;
	logic          sw_done;
	logic          ext_clk;
	logic [AW-3:0] grp;
	logic [3:0]    bvalid;
	logic [7:0]    bdata [0:3];
	logic [23:0]   prog_cnt;
	logic [1:0]    widx;
	logic [AW-1:0] baddr;
	logic          verify;
	logic [7:0]    cap;
	logic [20:0]   flash_cnt;
	logic          green;
	logic          red;
	logic          sel_mem;
	logic [7:0]    rdata_reg;
	logic          port_d_line_two_q;

	// bus decode
	wire [AW-1:0] bus_a      = addr[AW-1:0];
	wire          hit_ctrl   = addr == `OTP_CTRL_ADDR;
	wire          hit_opt    = addr == `OTP_OPTION_ADDR;
	wire          hit_arr    = (addr[15:AW] == '0) && is_array(bus_a);
	wire          in_boot    = boot_mode != otp_pkg::mode_single_chip;
	wire          run        = init_st == otp_pkg::init_run;
	wire          buf_empty  = bvalid == 4'h0;
	wire          latch_wr   = wr && hit_arr && latch && !pulse &&
		(buf_empty || bus_a[AW-1:2] == grp);
	wire          ctrl_wr    = wr && hit_ctrl;
	wire          latch_drop = (ctrl_wr && !wdata[`OTP_CTRL_LATCH]) || stop_entry;
	wire          opt_wr     = wr && hit_opt && in_boot;

	// engine
	wire          sw_go      = pulse && supply_s && !sw_done && eng_st == otp_pkg::eng_idle;
	wire          boot_go    = boot_st == otp_pkg::boot_prog && eng_st == otp_pkg::eng_idle &&
		!buf_empty; // an empty group must not start a pulse that clears the next group
	wire [23:0]   prog_limit = port_d_line_two_q ? 24'(PROG_SLOW) : 24'(PROG_FAST);
	wire [AW-1:0] eng_a      = {grp, widx};
	wire          eng_wr     = eng_st == otp_pkg::eng_write && bvalid[widx] &&
		!(option[`OTP_OPT_PROTECT] && is_main(eng_a));
	wire          eng_last   = eng_st == otp_pkg::eng_write && widx == 2'h3;

	// memory port, engine first
	wire boot_rd = boot_st == otp_pkg::boot_scan_rd || boot_st == otp_pkg::boot_cmp_rd;
	wire init_rd = init_st == otp_pkg::init_opt_rd;
	wire busy    = eng_st == otp_pkg::eng_write || boot_rd || init_rd || opt_wr;
	wire bus_rd  = rd && hit_arr && !latch && !busy;
	assign mem.wr_en = eng_wr || (opt_wr && eng_st != otp_pkg::eng_write);
	assign mem.rd_en = boot_rd || init_rd || bus_rd;
	assign mem.addr  = (eng_st == otp_pkg::eng_write) ? eng_a :
		boot_rd ? baddr : (init_rd || opt_wr) ? AW'(`OTP_OPTION_ADDR) : bus_a;
	assign mem.wdata = (eng_st == otp_pkg::eng_write) ? bdata[widx] :
		(wdata & `OTP_OPT_RD_MASK);

	// reset release: pins, option load, hold time
	wire [11:0] hold_limit = option[`OTP_OPT_HOLD] ? 12'(`OTP_HOLD_SHORT) :
		12'(`OTP_HOLD_LONG);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			init_st  <= otp_pkg::init_sync;
			pin_cnt  <= 2'h0;
			hold_cnt <= 12'h000;
			option   <= 8'h00;
			boot_mode <= otp_pkg::mode_single_chip;
			port_d_line_two_q <= 1'b0;
		end else begin
			case (init_st)
				otp_pkg::init_sync: begin
					pin_cnt <= pin_cnt + 2'h1;
					if (pin_cnt == PIN_HOLD) begin
						init_st <= otp_pkg::init_opt_rd;
						port_d_line_two_q <= pin_s[11];
						if (pin_s[13] && pin_s[12]) begin
							casez (pin_s[11:9])
								3'b010:  boot_mode <= otp_pkg::mode_erased_check;
								3'b?00:  boot_mode <= otp_pkg::mode_parallel_load;
								3'b?11:  boot_mode <= otp_pkg::mode_serial_load;
								3'b?01:  boot_mode <= otp_pkg::mode_ram_parallel;
								default: boot_mode <= otp_pkg::mode_single_chip;
							endcase
						end
					end
				end
				otp_pkg::init_opt_rd: init_st <= otp_pkg::init_opt_cap;
				otp_pkg::init_opt_cap: begin
					option  <= mem.rdata & `OTP_OPT_RD_MASK;
					init_st <= otp_pkg::init_hold;
				end
				otp_pkg::init_hold: begin
					hold_cnt <= hold_cnt + 12'h001;
					if (hold_cnt == hold_limit - 12'h001) begin
						init_st <= otp_pkg::init_run;
					end
				end
				otp_pkg::init_run: begin
					if (opt_wr) begin
						option <= option | (wdata & `OTP_OPT_RD_MASK);
					end
				end
				default: init_st <= otp_pkg::init_sync;
			endcase
		end
	end

	// control register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			latch   <= 1'b0;
			pulse   <= 1'b0;
			ext_clk <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ext_clk <= wdata[`OTP_CTRL_EXTCLK];
			end
			if (latch_drop) begin
				latch <= 1'b0;
				pulse <= 1'b0;
			end else if (ctrl_wr) begin
				latch <= 1'b1;
				if (wdata[`OTP_CTRL_PULSE] && latch && !buf_empty) begin
					pulse <= 1'b1;
				end
			end
		end
	end

	// byte buffer and programming engine
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			eng_st   <= otp_pkg::eng_idle;
			prog_cnt <= 24'h000000;
			widx     <= 2'h0;
			bvalid   <= 4'h0;
			grp      <= '0;
			sw_done  <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				bdata[i] <= 8'h00;
			end
		end else begin
			case (eng_st)
				otp_pkg::eng_idle: begin
					prog_cnt <= 24'h000000;
					if (sw_go || boot_go) begin
						eng_st <= otp_pkg::eng_time;
					end
				end
				otp_pkg::eng_time: begin
					prog_cnt <= prog_cnt + 24'h000001;
					if (prog_cnt == prog_limit - 24'h000001) begin
						eng_st <= otp_pkg::eng_write;
						widx   <= 2'h0;
					end
				end
				otp_pkg::eng_write: begin
					widx <= widx + 2'h1;
					if (eng_last) begin
						eng_st  <= otp_pkg::eng_idle;
						bvalid  <= 4'h0;
						sw_done <= !in_boot;
					end
				end
				default: eng_st <= otp_pkg::eng_idle;
			endcase
			if (latch_drop && !in_boot) begin
				bvalid  <= 4'h0;
				sw_done <= 1'b0;
			end else if (latch_wr) begin
				grp                 <= bus_a[AW-1:2];
				bvalid[bus_a[1:0]]  <= 1'b1;
				bdata[bus_a[1:0]]   <= wdata;
			end else if (boot_st == otp_pkg::boot_wait_rel && !verify && !ack_s) begin
				grp                 <= baddr[AW-1:2];
				bvalid[baddr[1:0]]  <= cap != 8'h00;
				bdata[baddr[1:0]]   <= cap;
			end
		end
	end

	// bootstrap sequencer
	wire last_addr = baddr == MAIN_TOP;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			boot_st   <= otp_pkg::boot_idle;
			baddr     <= '0;
			verify    <= 1'b0;
			cap       <= 8'h00;
			green     <= 1'b0;
			red       <= 1'b0;
			flash_cnt <= 21'h000000;
			compare_output_one <= 1'b0;
			handshake_line_a   <= 1'b0;
		end else begin
			case (boot_st)
				otp_pkg::boot_idle: begin
					baddr <= AW'(`OTP_SMALL_LO);
					if (run && in_boot) begin
						compare_output_one <= 1'b1;
						if (boot_mode == otp_pkg::mode_erased_check) begin
							boot_st <= otp_pkg::boot_scan_rd;
						end else if (boot_mode == otp_pkg::mode_parallel_load) begin
							boot_st <= otp_pkg::boot_req;
						end
					end
				end
				otp_pkg::boot_scan_rd: boot_st <= otp_pkg::boot_scan_chk;
				otp_pkg::boot_scan_chk: begin
					baddr <= next_array_addr(baddr);
					if (mem.rdata != 8'h00) begin
						boot_st <= otp_pkg::boot_fail;
					end else if (last_addr) begin
						boot_st <= otp_pkg::boot_pass;
					end else begin
						boot_st <= otp_pkg::boot_scan_rd;
					end
				end
				otp_pkg::boot_req: begin
					handshake_line_a <= 1'b1;
					boot_st          <= otp_pkg::boot_wait_ack;
				end
				otp_pkg::boot_wait_ack: begin
					if (ack_s) begin
						cap              <= data_s;
						handshake_line_a <= 1'b0;
						boot_st          <= otp_pkg::boot_wait_rel;
					end
				end
				otp_pkg::boot_wait_rel: begin
					if (!ack_s) begin
						if (verify) begin
							boot_st <= otp_pkg::boot_cmp_rd;
						end else if (baddr[1:0] == 2'h3) begin
							boot_st <= otp_pkg::boot_prog;
						end else begin
							baddr   <= baddr + AW'(1);
							boot_st <= otp_pkg::boot_req;
						end
					end
				end
				otp_pkg::boot_prog: begin
					if (eng_last || (buf_empty && eng_st == otp_pkg::eng_idle)) begin
						baddr   <= last_addr ? AW'(`OTP_SMALL_LO) : next_array_addr(baddr);
						verify  <= last_addr;
						boot_st <= otp_pkg::boot_req;
					end
				end
				otp_pkg::boot_cmp_rd: boot_st <= otp_pkg::boot_cmp;
				otp_pkg::boot_cmp: begin
					baddr <= next_array_addr(baddr);
					if (mem.rdata != cap) begin
						boot_st <= otp_pkg::boot_fail;
					end else if (last_addr) begin
						boot_st <= otp_pkg::boot_pass;
					end else begin
						boot_st <= otp_pkg::boot_req;
					end
				end
				otp_pkg::boot_pass: begin
					green <= 1'b1;
					red   <= 1'b0;
				end
				otp_pkg::boot_fail: begin
					green <= 1'b0;
					red   <= 1'b1;
				end
				default: boot_st <= otp_pkg::boot_idle;
			endcase
			// flashing only while loading, not while verifying
			if (boot_mode == otp_pkg::mode_parallel_load && !verify &&
				boot_st != otp_pkg::boot_idle) begin
				if (flash_cnt == 21'(FLASH_HALF - 1)) begin
					flash_cnt <= 21'h000000;
					green     <= !green;
				end else begin
					flash_cnt <= flash_cnt + 21'h000001;
				end
			end
		end
	end

	// register read port
	wire [7:0] ctrl_val = {1'b0, option[`OTP_OPT_PROTECT], latch, pulse, ext_clk, 3'h0};
	wire [7:0] read_val = hit_ctrl ? ctrl_val : hit_opt ? (option & `OTP_OPT_RD_MASK) : 8'h00;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sel_mem   <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			sel_mem   <= bus_rd;
			rdata_reg <= rd ? read_val : 8'h00;
		end
	end
	assign rdata = sel_mem ? mem.rdata : rdata_reg;

	// option, control register and bootstrap driven outputs
	assign reset_hold_n            = run || (init_st == otp_pkg::init_hold &&
		hold_cnt == hold_limit);
	assign watchdog_after_reset_en = option[`OTP_OPT_WD_RESET] && !in_boot;
	assign watchdog_in_wait_en     = option[`OTP_OPT_WD_WAIT];
	assign port_b_pulldown_en      = {8{option[`OTP_OPT_PB_PD]}} & ~port_b_dir;
	assign port_c_pulldown_en      = {8{option[`OTP_OPT_PC_PD]}} & ~port_c_dir;
	assign external_clock_option   = ext_clk;
	assign ext_addr                = baddr;
	assign led_green               = green;
	assign led_red                 = red;
endmodule : otp_program_control

// file: tb/otp_ext_source.sv
// external parallel byte source with request/acknowledge handshake
`timescale 1ns/10ps
module otp_ext_source #(
	parameter int AW = 13
) (
	// clock and reset
	input wire logic          mclk,
	input wire logic          arst_n,
	// parallel link
	input wire logic          handshake_line_a,
	input wire logic [AW-1:0] ext_addr,
	output logic              handshake_line_b,
	output logic [7:0]        port_a_in,
	output int                fault_cnt
);
	`include "otp_src_data.svh"
	int            wait_cnt;
	logic [AW-1:0] last_addr;
	// every fourth byte answers late, the rest promptly
	wire logic late = ext_addr[1:0] == 2'b11;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			handshake_line_b <= 1'b0;
			port_a_in <= 8'h00;
			wait_cnt <= 0;
			fault_cnt <= 0;
			last_addr <= '0;
		end else if (handshake_line_a && !handshake_line_b) begin
			if (late && wait_cnt < 2) begin
				wait_cnt <= wait_cnt + 1;
			end else begin
				port_a_in <= src_byte(ext_addr);
				handshake_line_b <= 1'b1;
				wait_cnt <= 0;
				last_addr <= ext_addr;
				// second pass restarts at the first array byte
				if (ext_addr <= last_addr && ext_addr != 13'h0100) begin
					fault_cnt <= fault_cnt + 1;
				end
			end
		end else if (!handshake_line_a && handshake_line_b) begin
			handshake_line_b <= 1'b0;
			port_a_in <= ~port_a_in;
		end
	end
endmodule : otp_ext_source

// file: tb/otp_program_control_chk.sv
// port assertions for the array control block
`timescale 1ns/10ps
`include "otp_consts.svh"
module otp_program_control_chk #(
	parameter int AW = 13
) (
	// clock and reset
	input wire logic                mclk,
	input wire logic                arst_n,
	// register port
	input wire logic [15:0]         addr,
	input wire logic [7:0]          wdata,
	input wire logic                wr,
	input wire logic                rd,
	input wire logic [7:0]          rdata,
	// core status
	input wire logic                stop_entry,
	input wire logic [7:0]          port_b_dir,
	input wire logic [7:0]          port_c_dir,
	// pins and options
	input wire logic                handshake_line_b,
	input wire logic                handshake_line_a,
	input wire logic [AW-1:0]       ext_addr,
	input wire logic                compare_output_one,
	input wire logic                led_green,
	input wire logic                led_red,
	input wire logic [7:0]          port_b_pulldown_en,
	input wire logic [7:0]          port_c_pulldown_en,
	input wire otp_pkg::boot_mode_t boot_mode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire logic ctrl_rd = rd && addr == `OTP_CTRL_ADDR;
	wire logic arr_rd  = rd && addr >= 16'h0100 && addr <= 16'h1DFF;
	wire logic in_map  = (ext_addr >= 13'h0100 && ext_addr <= 13'h01FF) || ext_addr >= 13'h0800;
	ctrl_top_zero_a: assert property (ctrl_rd |=> rdata[7] == 1'b0 && rdata[2:0] == 3'h0)
		else $error("control read shows reserved bits");
	opt_reserved_zero_a: assert property (rd && addr == `OTP_OPTION_ADDR |=> !rdata[7] && !rdata[5])
		else $error("option read shows reserved bits");
	pulse_needs_latch_a: assert property (ctrl_rd |=> !rdata[4] || rdata[5])
		else $error("pulse enable without latch");
	stop_clears_latch_a: assert property (stop_entry ##1 ctrl_rd |=> rdata[5:4] == 2'b00)
		else $error("stop left latch or pulse set");
	latched_read_zero_a: assert property (
		(wr && addr == `OTP_CTRL_ADDR && wdata[5]) ##1 !wr ##1 arr_rd |=> rdata == 8'h00)
		else $error("array readable while latch set");
	pulldown_input_a: assert property (((port_b_pulldown_en & port_b_dir) == 8'h00)
		&& (port_c_pulldown_en & port_c_dir) == 8'h00
		&& (port_b_pulldown_en == 8'h00 || port_b_pulldown_en == ~port_b_dir))
		else $error("pull-down on output pin");
	compare_in_boot_a: assert property (compare_output_one |-> boot_mode != otp_pkg::mode_single_chip)
		else $error("compare output high outside bootstrap");
	ack_before_drop_a: assert property ($fell(handshake_line_a) |-> $past(handshake_line_b, 2))
		else $error("request dropped without acknowledge");
	addr_stable_req_a: assert property (handshake_line_a ##1 handshake_line_a |-> $stable(ext_addr))
		else $error("address moved during request");
	req_in_array_a: assert property (handshake_line_a |-> in_map && ext_addr <= 13'h1DFF)
		else $error("request outside array segments");
	leds_exclusive_a: assert property (!(led_green && led_red))
		else $error("both indicators lit");
	erased_pass_c: cover property (boot_mode == otp_pkg::mode_erased_check && led_green);
	load_pass_c: cover property (boot_mode == otp_pkg::mode_parallel_load && led_green && !handshake_line_a);
	stop_clear_c: cover property (stop_entry ##1 ctrl_rd);
endmodule : otp_program_control_chk
bind otp_program_control otp_program_control_chk #(.AW(AW)) chk (.mclk(mclk), .arst_n(arst_n),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_entry(stop_entry),
	.port_b_dir(port_b_dir), .port_c_dir(port_c_dir), .handshake_line_b(handshake_line_b),
	.handshake_line_a(handshake_line_a), .ext_addr(ext_addr), .led_green(led_green),
	.compare_output_one(compare_output_one), .led_red(led_red), .boot_mode(boot_mode),
	.port_b_pulldown_en(port_b_pulldown_en), .port_c_pulldown_en(port_c_pulldown_en));

// file: tb/otp_src_data.svh
// byte pattern served by the external source model
// no guard: it is included inside each module that needs it
// few nonzero bytes keep most of the array erased and the load short
function automatic logic [7:0] src_byte(input logic [12:0] a);
	return (a < 13'h0110 || (a >= 13'h0800 && a < 13'h0808)) ? (a[7:0] ^ 8'hA5) : 8'h00;
endfunction : src_byte

// file: tb/tb_top.sv
// self-checking bench for the array control block
`timescale 1ns/10ps
module tb_top;
	`include "otp_src_data.svh"
	localparam int PF = 8;
	logic mclk, arst_n, wr, rd, stop_entry, programming_supply;
	logic irq_boot_level, capture_input_one, handshake_line_a, handshake_line_b;
	logic port_d_line_two, port_d_line_three, port_d_line_four;
	logic [15:0] addr, a;
	logic [7:0] wdata, rdata, port_a_in, port_b_dir, port_c_dir, pd_b, pd_c;
	logic [12:0] ext_addr;
	logic compare_output_one, led_green, led_red, reset_hold_n, wd_rst, wd_wait, ext_clk;
	otp_pkg::boot_mode_t boot_mode;
	int error_cnt, n_compared, src_faults, seed, hold_cyc, fl;
	logic [7:0] mem_model [int];
	otp_program_control #(.PROG_FAST(PF), .PROG_SLOW(2 * PF), .FLASH_HALF(4),
		.MAIN_HI(13'h08FF)) DUT (
		.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .stop_entry(stop_entry), .port_b_dir(port_b_dir), .port_c_dir(port_c_dir),
		.programming_supply(programming_supply), .irq_boot_level(irq_boot_level),
		.capture_input_one(capture_input_one), .port_d_line_two(port_d_line_two),
		.port_d_line_three(port_d_line_three), .port_d_line_four(port_d_line_four),
		.port_a_in(port_a_in), .handshake_line_b(handshake_line_b),
		.handshake_line_a(handshake_line_a), .ext_addr(ext_addr),
		.compare_output_one(compare_output_one), .led_green(led_green), .led_red(led_red),
		.reset_hold_n(reset_hold_n), .watchdog_after_reset_en(wd_rst),
		.watchdog_in_wait_en(wd_wait), .port_b_pulldown_en(pd_b), .port_c_pulldown_en(pd_c),
		.external_clock_option(ext_clk), .boot_mode(boot_mode));
	otp_ext_source src (.mclk(mclk), .arst_n(arst_n), .handshake_line_a(handshake_line_a),
		.ext_addr(ext_addr), .handshake_line_b(handshake_line_b), .port_a_in(port_a_in),
		.fault_cnt(src_faults));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	// each strobe is followed by an idle cycle so no signal is driven twice per step
	task automatic bus_wr(input logic [15:0] wa, input logic [7:0] d);
		addr <= wa;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask : bus_wr
	task automatic rd_chk(input string what, input logic [15:0] ra, input logic [7:0] exp);
		addr <= ra;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 check(what, rdata, exp);
		@(posedge mclk);
	endtask : rd_chk
	task automatic do_reset(input logic boot, input logic [2:0] pd);
		arst_n <= 1'b0;
		irq_boot_level <= boot;
		capture_input_one <= boot;
		{port_d_line_four, port_d_line_three, port_d_line_two} <= pd;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		for (hold_cyc = 0; reset_hold_n !== 1'b1 && hold_cyc < 5000; hold_cyc++) @(negedge mclk);
		@(posedge mclk);
	endtask : do_reset
	// ends on red, or on green once the link has gone quiet
	task automatic wait_boot(input int lim);
		int idle;
		logic g;
		idle = 0;
		fl = 0;
		g = led_green;
		for (int i = 0; i < 120000 && !(led_red || (led_green && idle >= lim)); i++) begin
			@(negedge mclk);
			idle = handshake_line_a ? 0 : idle + 1;
			fl += int'(led_green !== g);
			g = led_green;
		end
		@(posedge mclk);
	endtask : wait_boot
	task automatic prog(input logic [15:0] pa, input logic [7:0] d, input logic upd);
		bus_wr(16'h0007, 8'hFF);
		rd_chk("latched", pa, 8'h00);
		rd_chk("ctrl", 16'h0007, 8'h68);
		bus_wr(pa, d);
		bus_wr(pa + 16'h0004, d);
		bus_wr(16'h0007, 8'h38);
		bus_wr(16'h0007, 8'h28);
		rd_chk("ctrl", 16'h0007, 8'h78);
		programming_supply <= 1'b1;
		repeat (PF + 20) @(posedge mclk);
		programming_supply <= 1'b0;
		bus_wr(16'h0007, 8'h08);
		rd_chk("ctrl", 16'h0007, 8'h48);
		if (upd) mem_model[pa] = src_byte(pa[12:0]) | d;
	endtask : prog
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#6_000_000;
		error_cnt++;
		complete_run();
	end
	initial begin
		seed = 32'h8f9f2873;
		{arst_n, wr, rd, stop_entry, programming_supply, irq_boot_level} = '0;
		{capture_input_one, port_d_line_two, port_d_line_three, port_d_line_four} = '0;
		{addr, wdata, port_b_dir, port_c_dir} = '0;
		@(posedge mclk);
		do_reset(1'b1, 3'b010);
		check("hold long", 16'(hold_cyc >= 4064 && hold_cyc < 4080), 16'h1);
		wait_boot(0);
		check("mode", boot_mode, otp_pkg::mode_erased_check);
		check("compare out", compare_output_one, 1'b1);
		check("leds", {led_green, led_red}, 2'b10);
		$display("test erased check done");
		do_reset(1'b1, 3'b000);
		wait_boot(64);
		check("mode", boot_mode, otp_pkg::mode_parallel_load);
		check("leds", {led_green, led_red}, 2'b10);
		check("flashing", 16'(fl > 2), 16'h1);
		check("source order", 16'(src_faults), 16'h0);
		bus_wr(16'h1EFE, 8'h7E);
		$display("test parallel load done");
		do_reset(1'b0, 3'b000);
		check("hold short", 16'(hold_cyc >= 16 && hold_cyc < 32), 16'h1);
		check("mode", boot_mode, otp_pkg::mode_single_chip);
		check("watchdog", {wd_rst, wd_wait}, 2'b11);
		rd_chk("option", 16'h1EFE, 8'h5E);
		bus_wr(16'h1EFE, 8'h01);
		rd_chk("option", 16'h1EFE, 8'h5E);
		rd_chk("ctrl", 16'h0007, 8'h40);
		rd_chk("unmapped", 16'h0003, 8'h00);
		for (int i = 0; i < 4; i++) begin
			port_b_dir <= 8'($random(seed));
			port_c_dir <= 8'($random(seed));
			@(negedge mclk);
			check("pull b", pd_b, 8'(~port_b_dir));
			check("pull c", pd_c, 8'h00);
			@(posedge mclk);
		end
		prog(16'h0101, 8'($random(seed)) | 8'h01, 1'b1);
		prog(16'h0805, 8'h0F, 1'b0);
		check("ext clock", ext_clk, 1'b1);
		for (int i = 0; i < 12; i++) begin
			a = (i < 6) ? 16'h0100 + 16'(i) : 16'h07FE + 16'(i);
			rd_chk("array", a, mem_model.exists(a) ? mem_model[a] : src_byte(a[12:0]));
		end
		$display("test programming done");
		bus_wr(16'h0007, 8'h20);
		stop_entry <= 1'b1;
		@(posedge mclk);
		stop_entry <= 1'b0;
		rd_chk("ctrl", 16'h0007, 8'h40);
		$display("test stop done");
		complete_run();
	end
endmodule : tb_top
